/* File: core/thfa_consts.svh */
// named offsets, field positions, reset values and timing figures
`ifndef THFA_CONSTS_SVH
`define THFA_CONSTS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define THFA_ADDR_GEN_CMD 12'h000
`define THFA_ADDR_STATUS 12'h004
`define THFA_RX_PAGE 4'h1
`define THFA_TX_PAGE 4'h2
`define THFA_GCR_EDGE_BIT 1
`define THFA_GCR_POL_BIT 2
`define THFA_GCR_CLK_LSB 4
`define THFA_GCR_CLK_MSB 5
`define THFA_GCR_RESET 32'h0000_0026
`define THFA_CFG_WIDTH 14
`define THFA_CFG_RESET 14'h3000
`define THFA_ST_LOCK_BIT 0
`define THFA_ST_READY_BIT 1
// ----------------------------------------
// timing
// ----------------------------------------
`define THFA_CLK_PERIOD_NS 10
`define THFA_LOCK_TIME_NS 250000
`define THFA_RESET_TIME_NS 200
`define THFA_STALL_CYCLES 8'h40
// ----------------------------------------
// frame geometry
// ----------------------------------------
`define THFA_QTR_PER_SLOT_LOG 5
`define THFA_QTR_PER_BIT_LOG 2
`define THFA_LAST_BIT 3'h7
`define THFA_SEP_SLOTS 8'h02
`define THFA_SEP_FIXED_UNITS 16'h0004
`define THFA_UNIT_SHIFT_MAX 3'h2
`define THFA_FULL_SLOT_MASK 7'h7F
`endif

/* File: core/thfa_frame_align.sv */
// frame alignment, highway timing, reset sequencing and low-latency frame choice
//
// Functional notes
// - frame pulse starts the physical frame; slot 0 may sit anywhere in it
// - slot offset reaches 31, 63 or 127 slots by rate, rx and tx separately
// - whole-bit offset of up to seven bits per highway
// - quarter-bit offset of 0, 1/4, 1/2 or 3/4 bit per highway
// - every highway holds its own offsets, no coupling between highways
// - offsets are counted in the highway's own bit period
// - polarity control at command bit 2, one means active-high pulse
// - edge control at command bit 1, one means rising-edge sampling
// - zero offsets: rx bit 0 of slot 0 latched on the pulse edge
// - zero offsets: tx bit 0 of slot 0 driven from the pulse edge
// - 8.192 MHz clock, 4.096 rx, 3/4 bit: sample 1.5 clocks later
// - 8.192 MHz clock, 2.048 tx, one bit: drive four clocks later
// - internal reset ends 200 ns after lock, lock 250 us after clock starts
// - reset input is asynchronous, no timing to any clock
// - each tx slot picks minimum-delay or frame-preserving forwarding
// - minimum-delay data too close or early goes next frame; latency bounded
// - current frame needs two rx slots plus (4+i) units separation
// - with offsets, compare slot plus offset on both sides
// - two-bit rate field per highway: three rates or idle
`timescale 1ns/1ps
`include "thfa_consts.svh"
module thfa_frame_align #(
  parameter int NUM_HW = 32,
  parameter int LOCK_CYCLES = (`THFA_LOCK_TIME_NS + `THFA_CLK_PERIOD_NS - 1) / `THFA_CLK_PERIOD_NS
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic powerOnReset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic highwayClockIn,
  input wire logic framePulse,
  input wire logic [NUM_HW-1:0] rxHighwayLine,
  output logic [NUM_HW-1:0] txHighwayLine,
  output logic [NUM_HW-1:0] txHighwayLineOe,
  output thfa_pkg::thfa_bit_s [NUM_HW-1:0] rxSample,
  output thfa_pkg::thfa_bit_s [NUM_HW-1:0] txPosition,
  input wire logic [NUM_HW-1:0] txData,
  input wire logic [NUM_HW-1:0] txDrive,
  input wire thfa_pkg::thfa_query_s lowLatQuery,
  output thfa_pkg::thfa_answer_s lowLatAnswer,
  output logic pllLocked,
  output logic coreReady
);
  localparam int HW_W = (NUM_HW > 1) ? $clog2(NUM_HW) : 1;
  localparam int RESET_CYCLES = `THFA_RESET_TIME_NS / `THFA_CLK_PERIOD_NS;
  localparam logic [31:0] GCR_RESET = `THFA_GCR_RESET;

  // ----------------------------------------
  // pin synchronisers and edge finding
  // ----------------------------------------
  logic hcMeta;
  logic hcSync;
  logic hcPrev;
  logic fpMeta;
  logic fpSync;
  logic [NUM_HW-1:0] rxMeta;
  logic [NUM_HW-1:0] rxSync;
  logic [NUM_HW-1:0] rxDly;
  logic hcRise;
  logic hcFall;
  logic hcTick;
  logic fpActive;
  logic frameEdge;
  logic frameStart;
  logic timerTick;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hcMeta <= 1'b0;
      hcSync <= 1'b0;
      hcPrev <= 1'b0;
      fpMeta <= 1'b0;
      fpSync <= 1'b0;
    end else begin
      hcMeta <= highwayClockIn;
      hcSync <= hcMeta;
      hcPrev <= hcSync;
      fpMeta <= framePulse;
      fpSync <= fpMeta;
    end
  end

  // the rx lines pass the same depth as the clock so data and edges stay aligned
  genvar g;
  generate
    for (g = 0; g < NUM_HW; g = g + 1) begin : gRxSync
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          rxMeta[g] <= 1'b0;
          rxSync[g] <= 1'b0;
          rxDly[g] <= 1'b0;
        end else begin
          rxMeta[g] <= rxHighwayLine[g];
          rxSync[g] <= rxMeta[g];
          rxDly[g] <= rxSync[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // general command and status registers
  // ----------------------------------------
  logic [1:0] clockRate;
  logic framePulsePolarity;
  logic framePulseEdgeSelect;
  thfa_pkg::thfa_cfg_s rxCfg [NUM_HW];
  thfa_pkg::thfa_cfg_s txCfg [NUM_HW];

  assign hcRise = hcSync & ~hcPrev;
  assign hcFall = ~hcSync & hcPrev;
  assign hcTick = hcRise | hcFall;
  assign fpActive = framePulsePolarity ? fpSync : ~fpSync;
  assign frameEdge = framePulseEdgeSelect ? hcRise : hcFall;
  assign frameStart = frameEdge & fpActive;
  // nothing is timed before the internal reset has finished
  assign timerTick = hcTick & coreReady;

  // ----------------------------------------
  // clock monitor and reset sequencing
  // ----------------------------------------
  logic [7:0] stallCnt;
  logic clockStalled;
  logic [31:0] lockCnt;
  logic [7:0] rstCnt;

  assign clockStalled = stallCnt == `THFA_STALL_CYCLES;
  // lock survives reset_n, so a later reset with a running clock is short
  always_ff @(posedge clock or negedge powerOnReset_n) begin
    if (!powerOnReset_n) begin
      stallCnt <= 8'h00;
      lockCnt <= 32'h0000_0000;
      pllLocked <= 1'b0;
    end else begin
      if (hcTick) begin
        stallCnt <= 8'h00;
      end else if (!clockStalled) begin
        stallCnt <= stallCnt + 8'h01;
      end
      if (clockStalled) begin
        lockCnt <= 32'h0000_0000;
        pllLocked <= 1'b0;
      end else if (lockCnt == 32'(LOCK_CYCLES)) begin
        pllLocked <= 1'b1;
      end else begin
        lockCnt <= lockCnt + 32'h0000_0001;
      end
    end
  end

  // reset_n acts at once; the release is counted on the clock
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rstCnt <= 8'h00;
    end else if (!pllLocked) begin
      rstCnt <= 8'h00;
    end else if (rstCnt != 8'(RESET_CYCLES)) begin
      rstCnt <= rstCnt + 8'h01;
    end
  end
  assign coreReady = rstCnt == 8'(RESET_CYCLES);

  // ----------------------------------------
  // apb slave: zero wait states, read data caught in the setup phase
  // ----------------------------------------
  logic setupPhase;
  logic accessPhase;
  logic wordAligned;
  logic genHit;
  logic statusHit;
  logic rxHit;
  logic txHit;
  logic mapped;
  logic [HW_W-1:0] regIdx;
  logic [31:0] readMux;
  logic writeNow;

  assign setupPhase = psel & ~penable;
  assign accessPhase = psel & penable;
  assign wordAligned = paddr[1:0] == 2'h0;
  assign regIdx = paddr[2 +: HW_W];
  assign genHit = paddr == `THFA_ADDR_GEN_CMD;
  assign statusHit = paddr == `THFA_ADDR_STATUS;
  assign rxHit = wordAligned & (paddr[11:8] == `THFA_RX_PAGE) & (paddr[7:2] < 6'(NUM_HW));
  assign txHit = wordAligned & (paddr[11:8] == `THFA_TX_PAGE) & (paddr[7:2] < 6'(NUM_HW));
  assign mapped = genHit | statusHit | rxHit | txHit;
  assign pready = 1'b1;
  assign pslverr = accessPhase & ~mapped;
  assign writeNow = accessPhase & pwrite & mapped;

  always_comb begin
    readMux = 32'h0000_0000;
    if (genHit) begin
      readMux[`THFA_GCR_CLK_MSB:`THFA_GCR_CLK_LSB] = clockRate;
      readMux[`THFA_GCR_POL_BIT] = framePulsePolarity;
      readMux[`THFA_GCR_EDGE_BIT] = framePulseEdgeSelect;
    end else if (statusHit) begin
      readMux[`THFA_ST_LOCK_BIT] = pllLocked;
      readMux[`THFA_ST_READY_BIT] = coreReady;
    end else if (rxHit) begin
      readMux[`THFA_CFG_WIDTH-1:0] = rxCfg[regIdx];
    end else if (txHit) begin
      readMux[`THFA_CFG_WIDTH-1:0] = txCfg[regIdx];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (setupPhase && !pwrite) begin
      prdata <= readMux;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clockRate <= GCR_RESET[`THFA_GCR_CLK_MSB:`THFA_GCR_CLK_LSB];
      framePulsePolarity <= GCR_RESET[`THFA_GCR_POL_BIT];
      framePulseEdgeSelect <= GCR_RESET[`THFA_GCR_EDGE_BIT];
    end else if (writeNow && genHit) begin
      clockRate <= pwdata[`THFA_GCR_CLK_MSB:`THFA_GCR_CLK_LSB];
      framePulsePolarity <= pwdata[`THFA_GCR_POL_BIT];
      framePulseEdgeSelect <= pwdata[`THFA_GCR_EDGE_BIT];
    end
  end

  // ----------------------------------------
  // per-highway configuration, timers and line logic
  // ----------------------------------------
  logic [NUM_HW-1:0] rxStrobe;
  logic [NUM_HW-1:0] txStrobe;
  logic [6:0] rxSlot [NUM_HW];
  logic [2:0] rxBit [NUM_HW];
  logic [6:0] txSlot [NUM_HW];
  logic [2:0] txBit [NUM_HW];

  generate
    for (g = 0; g < NUM_HW; g = g + 1) begin : gHighway
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          rxCfg[g] <= `THFA_CFG_RESET;
          txCfg[g] <= `THFA_CFG_RESET;
        end else if (writeNow && regIdx == HW_W'(g)) begin
          if (rxHit) begin
            rxCfg[g] <= pwdata[`THFA_CFG_WIDTH-1:0];
          end
          if (txHit) begin
            txCfg[g] <= pwdata[`THFA_CFG_WIDTH-1:0];
          end
        end
      end

      thfa_highway_timer uRxTimer (
        .clock(clock),
        .reset_n(reset_n),
        .tick(timerTick),
        .frameStart(frameStart),
        .clockRate(clockRate),
        .cfg(rxCfg[g]),
        .bitStrobe(rxStrobe[g]),
        .slot(rxSlot[g]),
        .bitIdx(rxBit[g])
      );

      thfa_highway_timer uTxTimer (
        .clock(clock),
        .reset_n(reset_n),
        .tick(timerTick),
        .frameStart(frameStart),
        .clockRate(clockRate),
        .cfg(txCfg[g]),
        .bitStrobe(txStrobe[g]),
        .slot(txSlot[g]),
        .bitIdx(txBit[g])
      );

      // the user supplies the bit in the cycle txPosition is valid
      assign txPosition[g] = '{valid: txStrobe[g], data: 1'b0, slot: txSlot[g],
                               bitIdx: txBit[g]};

      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          rxSample[g] <= '0;
          txHighwayLine[g] <= 1'b0;
          txHighwayLineOe[g] <= 1'b0;
        end else begin
          rxSample[g].valid <= rxStrobe[g];
          if (rxStrobe[g]) begin
            rxSample[g].data <= rxDly[g];
            rxSample[g].slot <= rxSlot[g];
            rxSample[g].bitIdx <= rxBit[g];
          end
          if (txCfg[g].highwayRateField == thfa_pkg::RATE_IDLE) begin
            txHighwayLineOe[g] <= 1'b0;
          end else if (txStrobe[g]) begin
            txHighwayLine[g] <= txData[g];
            txHighwayLineOe[g] <= txDrive[g];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // low-latency frame choice
  // ----------------------------------------
  // position in units of a quarter bit at the fastest rate
  function automatic logic [15:0] unitsOf(input logic [7:0] slotNum,
                                          input thfa_pkg::thfa_cfg_s cfg);
    logic [2:0] rateNum;
    logic [6:0] slotMask;
    logic [15:0] quarters;
    rateNum = (cfg.highwayRateField == thfa_pkg::RATE_IDLE) ? `THFA_UNIT_SHIFT_MAX :
              {1'b0, cfg.highwayRateField};
    slotMask = `THFA_FULL_SLOT_MASK >> (`THFA_UNIT_SHIFT_MAX - rateNum);
    quarters = ({8'h00, slotNum} << `THFA_QTR_PER_SLOT_LOG) +
               {4'h0, cfg.slotShift & slotMask, cfg.wholeBitShift, cfg.quarterBitShift};
    unitsOf = quarters << (`THFA_UNIT_SHIFT_MAX - rateNum);
  endfunction : unitsOf

  logic [HW_W-1:0] qRxIdx;
  logic [HW_W-1:0] qTxIdx;
  logic [15:0] txUnits;
  logic [15:0] needUnits;
  logic currentFrame;

  assign qRxIdx = lowLatQuery.rxHighway[HW_W-1:0];
  assign qTxIdx = lowLatQuery.txHighway[HW_W-1:0];
  assign txUnits = unitsOf({1'b0, lowLatQuery.txSlot}, txCfg[qTxIdx]);
  // two rx slots ahead plus the fixed and per-highway internal delay
  assign needUnits = unitsOf({1'b0, lowLatQuery.rxSlot} + `THFA_SEP_SLOTS, rxCfg[qRxIdx]) +
                     `THFA_SEP_FIXED_UNITS + 16'(qTxIdx);
  assign currentFrame = txUnits >= needUnits;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lowLatAnswer <= '0;
    end else begin
      lowLatAnswer.valid <= lowLatQuery.valid;
      // frame-preserving slots never go out in the receive frame
      lowLatAnswer.nextFrame <= lowLatQuery.minDelay ? ~currentFrame : 1'b1;
    end
  end
endmodule : thfa_frame_align

/* File: core/thfa_highway_timer.sv */
// per-highway virtual frame timer
`timescale 1ns/1ps
`include "thfa_consts.svh"
module thfa_highway_timer (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic frameStart,
  input wire logic [1:0] clockRate,
  input wire thfa_pkg::thfa_cfg_s cfg,
  output logic bitStrobe,
  output logic [6:0] slot,
  output logic [2:0] bitIdx
);
  // ----------------------------------------
  // offset arithmetic, in half highway-clock periods
  // ----------------------------------------
  logic idle;
  logic [2:0] rateNum;
  logic [2:0] clkNum;
  logic [2:0] halfLog;
  logic [6:0] slotMask;
  logic [11:0] quarterTotal;
  logic [15:0] offsetWide;
  logic [15:0] offsetHalf;
  logic [4:0] halfPerBit;
  logic armed;
  logic running;
  logic [15:0] offCnt;
  logic [4:0] phase;
  logic fireNow;
  logic stepNow;

  assign idle = cfg.highwayRateField == thfa_pkg::RATE_IDLE;
  assign rateNum = idle ? `THFA_UNIT_SHIFT_MAX : {1'b0, cfg.highwayRateField};
  assign clkNum = {1'b0, clockRate} + 3'h1;
  // a clock slower than the bit rate cannot place quarter bits; it degrades to one tick a bit
  assign halfLog = (clkNum > rateNum) ? clkNum - rateNum : 3'h0;
  assign slotMask = `THFA_FULL_SLOT_MASK >> (`THFA_UNIT_SHIFT_MAX - rateNum);
  assign quarterTotal = {cfg.slotShift & slotMask, cfg.wholeBitShift, cfg.quarterBitShift};
  assign offsetWide = {4'h0, quarterTotal} << halfLog;
  assign offsetHalf = offsetWide >> `THFA_QTR_PER_BIT_LOG;
  assign halfPerBit = 5'h01 << halfLog;
  assign fireNow = tick & ~idle & ((frameStart & (offsetHalf == 16'h0000)) |
                   (armed & ~frameStart & (offCnt == offsetHalf)));
  assign stepNow = tick & running & ~fireNow & ((phase + 5'h01) == halfPerBit);

  // ----------------------------------------
  // counters
  // ----------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bitStrobe <= 1'b0;
      armed <= 1'b0;
      running <= 1'b0;
      offCnt <= 16'h0000;
      phase <= 5'h00;
      slot <= 7'h00;
      bitIdx <= 3'h0;
    end else begin
      bitStrobe <= fireNow | stepNow;
      if (tick && frameStart) begin
        armed <= ~idle & (offsetHalf != 16'h0000);
        offCnt <= 16'h0001;
      end else if (tick && armed) begin
        armed <= ~fireNow;
        offCnt <= offCnt + 16'h0001;
      end
      if (idle) begin
        running <= 1'b0;
      end else if (fireNow) begin
        running <= 1'b1;
        phase <= 5'h00;
        slot <= 7'h00;
        bitIdx <= 3'h0;
      end else if (stepNow) begin
        phase <= 5'h00;
        bitIdx <= bitIdx + 3'h1;
        if (bitIdx == `THFA_LAST_BIT) begin
          slot <= (slot + 7'h01) & slotMask;
        end
      end else if (tick && running) begin
        phase <= phase + 5'h01;
      end
    end
  end
endmodule : thfa_highway_timer

/* File: core/thfa_pkg.sv */
// types shared by the frame alignment block
package thfa_pkg;
  typedef enum logic [1:0] {RATE_2M048, RATE_4M096, RATE_8M192, RATE_IDLE} thfa_rate_e;

  typedef struct packed {
    thfa_rate_e highwayRateField;
    logic [1:0] quarterBitShift;
    logic [2:0] wholeBitShift;
    logic [6:0] slotShift;
  } thfa_cfg_s;

  typedef struct packed {
    logic valid;
    logic data;
    logic [6:0] slot;
    logic [2:0] bitIdx;
  } thfa_bit_s;

  typedef struct packed {
    logic valid;
    logic minDelay;
    logic [4:0] rxHighway;
    logic [6:0] rxSlot;
    logic [4:0] txHighway;
    logic [6:0] txSlot;
  } thfa_query_s;

  typedef struct packed {
    logic valid;
    logic nextFrame;
  } thfa_answer_s;
endpackage : thfa_pkg

/* File: testbench/thfa_frame_align_chk.sv */
// assertion checker for the frame alignment block
`timescale 1ns/1ps
module thfa_frame_align_chk #(
  parameter int NUM_HW = 32
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic powerOnReset_n,
  input wire logic [NUM_HW-1:0] txHighwayLine,
  input wire logic [NUM_HW-1:0] txHighwayLineOe,
  input wire thfa_pkg::thfa_bit_s [NUM_HW-1:0] rxSample,
  input wire thfa_pkg::thfa_bit_s [NUM_HW-1:0] txPosition,
  input wire logic [NUM_HW-1:0] txData,
  input wire logic [NUM_HW-1:0] txDrive,
  input wire thfa_pkg::thfa_query_s lowLatQuery,
  input wire thfa_pkg::thfa_answer_s lowLatAnswer,
  input wire logic pllLocked,
  input wire logic coreReady
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ----
  // sequences
  // ----
  sequence s_tx_take;
    txPosition[0].valid && txDrive[0];
  endsequence
  sequence s_tx_line;
    txHighwayLineOe[0] && (txHighwayLine[0] == $past(txData[0]));
  endsequence
  // ----
  // properties
  // ----
  property p_ready_after_lock;
    $rose(coreReady) |-> $past(pllLocked, 18) && $past(reset_n, 18);
  endproperty
  property p_ready_needs_lock;
    coreReady |-> pllLocked;
  endproperty
  property p_reset_quiet;
    disable iff (!powerOnReset_n) !reset_n |-> !coreReady && (txHighwayLineOe == '0);
  endproperty
  property p_quiet_before_ready;
    !coreReady |-> !rxSample[0].valid && !txPosition[0].valid;
  endproperty
  property p_tx_launch;
    s_tx_take |=> s_tx_line;
  endproperty
  property p_rx_strobe;
    rxSample[0].valid |=> !rxSample[0].valid [*3];
  endproperty
  property p_ll_answer;
    lowLatQuery.valid |=> lowLatAnswer.valid;
  endproperty
  property p_ll_preserve;
    lowLatQuery.valid && !lowLatQuery.minDelay |=> lowLatAnswer.nextFrame;
  endproperty
  a_ready_after_lock: assert property (p_ready_after_lock) else $error("ready early");
  a_ready_needs_lock: assert property (p_ready_needs_lock) else $error("ready no lock");
  a_reset_quiet: assert property (p_reset_quiet) else $error("active in reset");
  a_quiet_before_ready: assert property (p_quiet_before_ready) else $error("early strobe");
  a_tx_launch: assert property (p_tx_launch) else $error("tx line wrong");
  a_rx_strobe: assert property (p_rx_strobe) else $error("rx strobe long");
  a_ll_answer: assert property (p_ll_answer) else $error("no answer");
  a_ll_preserve: assert property (p_ll_preserve) else $error("preserve sent now");
endmodule : thfa_frame_align_chk

/* File: testbench/thfa_frame_align_tb.sv */
// self-checking bench for the frame alignment block
`timescale 1ns/1ps
`include "thfa_consts.svh"
module thfa_frame_align_tb;
  localparam int NHW = 4;
  localparam int LOCK = 50;
  logic clock, reset_n, powerOnReset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic highwayClockIn, framePulse, pllLocked, coreReady, pulseActiveHigh, pulseOnRise;
  logic armWant, armed, armLvl, lastPulse;
  logic [NHW-1:0] rxHighwayLine, txHighwayLine, txHighwayLineOe, txData, txDrive;
  thfa_pkg::thfa_bit_s [NHW-1:0] rxSample, txPosition;
  thfa_pkg::thfa_query_s lowLatQuery;
  thfa_pkg::thfa_answer_s lowLatAnswer;
  thfa_pkg::thfa_cfg_s rxCfg[NHW], txCfg[NHW];
  int error_cnt = 0, checked = 0, cyc = 0, armT = 0, dA = 0;
  int rxT[NHW], txT[NHW];
  logic rxD[NHW];
  thfa_frame_align #(.NUM_HW(NHW), .LOCK_CYCLES(LOCK)) u_thfa_frame_align (
    .clock(clock), .reset_n(reset_n), .powerOnReset_n(powerOnReset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .highwayClockIn(highwayClockIn),
    .framePulse(framePulse), .rxHighwayLine(rxHighwayLine), .txHighwayLine(txHighwayLine),
    .txHighwayLineOe(txHighwayLineOe), .rxSample(rxSample), .txPosition(txPosition),
    .txData(txData), .txDrive(txDrive), .lowLatQuery(lowLatQuery),
    .lowLatAnswer(lowLatAnswer), .pllLocked(pllLocked), .coreReady(coreReady));
  thfa_highway_partner #(.NUM_HW(NHW), .FRAME_CLKS(1024)) u_thfa_highway_partner (
    .pulseActiveHigh(pulseActiveHigh), .pulseOnRise(pulseOnRise),
    .highwayClockIn(highwayClockIn), .framePulse(framePulse), .rxHighwayLine(rxHighwayLine));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ----
  // frame event monitor: cycle of each highway's slot 0 bit 0
  // ----
  always @(posedge clock) begin
    cyc++;
    if (armWant && framePulse === armLvl && lastPulse !== armLvl) begin
      armWant = 1'b0;
      armed = 1'b1;
      armT = cyc;
      rxT = '{default: -1};
      txT = '{default: -1};
    end
    lastPulse = framePulse;
    for (int h = 0; h < NHW; h++) begin
      if (armed && rxT[h] < 0 && rxSample[h].valid === 1'b1 && rxSample[h].slot === 7'h00
          && rxSample[h].bitIdx === 3'h0) begin
        rxT[h] = cyc;
        rxD[h] = rxSample[h].data;
      end
      if (armed && txT[h] < 0 && txPosition[h].valid === 1'b1
          && txPosition[h].slot === 7'h00 && txPosition[h].bitIdx === 3'h0) begin
        txT[h] = cyc;
      end
    end
  end
  // ----
  // shared tasks
  // ----
  task automatic stop_test();
    if (error_cnt == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  task automatic check_ok(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      $display("CHECK FAILED at %0t: %s", $time, msg);
      error_cnt++;
    end
  endtask : check_ok
  task automatic give_up(input string msg);
    check_ok(1'b0, msg);
    stop_test();
  endtask : give_up
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) give_up("apb hang");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  task automatic arm(input logic lvl);
    armLvl = lvl;
    armed = 1'b0;
    armWant = 1'b1;
    for (int n = 0; n < 20000 && armed !== 1'b1; n++) @(posedge clock);
    if (armed !== 1'b1) give_up("no frame pulse");
  endtask : arm
  task automatic wait_ev(input int h, input logic tx);
    for (int n = 0; n < 20000 && (tx ? txT[h] : rxT[h]) < 0; n++) @(posedge clock);
    if ((tx ? txT[h] : rxT[h]) < 0) give_up("no frame event");
  endtask : wait_ev
  function automatic int units(input thfa_pkg::thfa_cfg_s c, input int slot);
    int b;
    b = 16 >> int'(c.highwayRateField);
    return (slot + c.slotShift) * 8 * b + c.wholeBitShift * b + c.quarterBitShift * (b / 4);
  endfunction : units
  task automatic ll_one(input int rh, input int rs, input int th, input int ts, input logic md);
    logic expNext;
    expNext = !(md && units(txCfg[th], ts) >= units(rxCfg[rh], rs + 2) + 4 + th);
    lowLatQuery <= {1'b1, md, 5'(rh), 7'(rs), 5'(th), 7'(ts)};
    @(posedge clock);
    lowLatQuery.valid <= 1'b0;
    @(negedge clock);
    check_ok(lowLatAnswer.valid === 1'b1 && lowLatAnswer.nextFrame === expNext, "latency");
    @(posedge clock);
  endtask : ll_one
  // ----
  // scenarios
  // ----
  task automatic test_reset();
    int n;
    for (n = 0; n < 200 && coreReady !== 1'b1; n++) @(posedge clock);
    check_ok(n >= LOCK + 20 && n <= LOCK + 30, "power-up ready delay");
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    check_ok(coreReady === 1'b0 && pllLocked === 1'b1, "reset state");
    reset_n <= 1'b1;
    for (n = 0; n < 200 && coreReady !== 1'b1; n++) @(posedge clock);
    check_ok(n >= 19 && n <= 22, "later reset delay");
  endtask : test_reset
  task automatic test_regs();
    apb(1'b0, `THFA_ADDR_GEN_CMD, 32'h0);
    check_ok(rd === `THFA_GCR_RESET && err === 1'b0, "command reset");
    apb(1'b0, 12'h100, 32'h0);
    check_ok(rd === 32'h0000_3000, "cfg reset idle");
    apb(1'b0, `THFA_ADDR_STATUS, 32'h0);
    check_ok(rd === 32'h0000_0003, "status ready");
    apb(1'b0, 12'h008, 32'h0);
    check_ok(err === 1'b1 && rd === 32'h0, "unmapped read");
    for (int h = 0; h < NHW; h++) begin
      apb(1'b1, 12'h100 + 12'(4 * h), 32'(rxCfg[h]));
      apb(1'b1, 12'h200 + 12'(4 * h), 32'(txCfg[h]));
    end
    for (int h = 0; h < NHW; h++) begin
      apb(1'b0, 12'h100 + 12'(4 * h), 32'h0);
      check_ok(rd === 32'(rxCfg[h]), "rx cfg readback");
      apb(1'b0, 12'h200 + 12'(4 * h), 32'h0);
      check_ok(rd === 32'(txCfg[h]), "tx cfg readback");
    end
  endtask : test_regs
  task automatic test_timing();
    arm(1'b1);
    wait_ev(3, 1'b0);
    dA = rxT[0] - armT;
    check_ok(rxD[0] === 1'b1 && rxD[2] === 1'b0, "first bit data");
    check_ok(rxT[1] - rxT[0] == 24, "rx three quarter bit");
    check_ok(rxT[2] - rxT[0] == 64, "rx one bit");
    check_ok(rxT[3] - rxT[0] == 12800, "rx slot shift");
    check_ok(txT[0] == rxT[0] - 1, "tx zero offset");
    check_ok(txT[1] - txT[0] == 64, "tx one bit");
    check_ok(txT[3] - txT[0] == 16, "tx half bit");
    check_ok(txT[2] < 0 && txHighwayLineOe[2] === 1'b0, "idle tx");
  endtask : test_timing
  task automatic test_edge_polarity();
    pulseActiveHigh <= 1'b0;
    pulseOnRise <= 1'b1;
    apb(1'b1, `THFA_ADDR_GEN_CMD, 32'h0000_0020);
    arm(1'b0);
    arm(1'b0);
    wait_ev(0, 1'b0);
    check_ok(rxT[0] - armT == dA, "falling edge low pulse");
  endtask : test_edge_polarity
  initial begin
    {reset_n, powerOnReset_n, psel, penable, pwrite, armWant, armed, pulseOnRise} = '0;
    paddr = '0;
    pwdata = '0;
    txData = 4'h5;
    txDrive = 4'hF;
    lowLatQuery = '0;
    pulseActiveHigh = 1'b1;
    rxCfg = '{14'h0000, 14'h1C00, 14'h0080, 14'h2064};
    txCfg = '{14'h0000, 14'h0080, 14'h3000, 14'h1800};
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    powerOnReset_n <= 1'b1;
    test_reset();
    test_regs();
    test_timing();
    ll_one(0, 0, 0, 2, 1'b1);
    ll_one(0, 0, 0, 3, 1'b1);
    ll_one(0, 0, 0, 3, 1'b0);
    ll_one(0, 0, 1, 2, 1'b1);
    ll_one(0, 0, 3, 4, 1'b1);
    ll_one(0, 0, 3, 5, 1'b1);
    ll_one(3, 0, 0, 25, 1'b1);
    ll_one(3, 0, 0, 26, 1'b1);
    test_edge_polarity();
    stop_test();
  end
endmodule : thfa_frame_align_tb
bind thfa_frame_align thfa_frame_align_chk #(.NUM_HW(NUM_HW)) u_thfa_frame_align_chk (
  .clock(clock), .reset_n(reset_n), .powerOnReset_n(powerOnReset_n),
  .txHighwayLine(txHighwayLine), .txHighwayLineOe(txHighwayLineOe), .rxSample(rxSample),
  .txPosition(txPosition), .txData(txData), .txDrive(txDrive), .lowLatQuery(lowLatQuery),
  .lowLatAnswer(lowLatAnswer), .pllLocked(pllLocked), .coreReady(coreReady));

/* File: testbench/thfa_highway_partner.sv */
// model of the tdm devices sharing the highway clock and frame pulse
`timescale 1ns/1ps
module thfa_highway_partner #(
  parameter int NUM_HW = 4,
  parameter int FRAME_CLKS = 1024
) (
  input wire logic pulseActiveHigh,
  input wire logic pulseOnRise,
  output logic highwayClockIn,
  output logic framePulse,
  output logic [NUM_HW-1:0] rxHighwayLine
);
  int clkCnt = 0;
  int phase;
  // backplane clock runs free, it is not gated between frames
  initial begin
    highwayClockIn = 1'b0;
    framePulse = 1'b0;
    rxHighwayLine = '0;
    forever #80 highwayClockIn = ~highwayClockIn;
  end
  always @(posedge highwayClockIn) clkCnt = (clkCnt + 1) % FRAME_CLKS;
  // change half a period ahead of the sampling edge
  always @(highwayClockIn) begin
    #1;
    if (highwayClockIn === pulseOnRise) begin
      phase = pulseOnRise ? clkCnt : (clkCnt + 1) % FRAME_CLKS;
      framePulse = (phase == 0) ? pulseActiveHigh : !pulseActiveHigh;
      rxHighwayLine = {NUM_HW{phase < 4}};
    end
  end
endmodule : thfa_highway_partner
